/* dac_pkg.sv */
/*
 package for the dma channel addressing core: register map, field codes, widths.
 assumes nothing of its surroundings.
*/
`default_nettype none
package dac_pkg;
    localparam int ADDR_W = 22;
    localparam int CNT_W  = 12;
    localparam int NUM_TRIG = 8;
    localparam int TSEL_W = 3;

    // address step codes
    localparam logic [1:0] STEP_FIXED = 2'h0;
    localparam logic [1:0] STEP_INC   = 2'h1;
    localparam logic [1:0] STEP_DEC   = 2'h2;

    // source memory region codes
    localparam logic [1:0] REG_RAM   = 2'h0;
    localparam logic [1:0] REG_FLASH = 2'h1;
    localparam logic [1:0] REG_EEP   = 2'h2;

    // avalon word offsets (byte addresses)
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_CFG    = 6'h04;
    localparam logic [5:0] OFS_SSA    = 6'h08;
    localparam logic [5:0] OFS_DSA    = 6'h0C;
    localparam logic [5:0] OFS_SSZ    = 6'h10;
    localparam logic [5:0] OFS_DSZ    = 6'h14;
    localparam logic [5:0] OFS_SPTR   = 6'h18;
    localparam logic [5:0] OFS_DPTR   = 6'h1C;
    localparam logic [5:0] OFS_SCNT   = 6'h20;
    localparam logic [5:0] OFS_DCNT   = 6'h24;
    localparam logic [5:0] OFS_BUF    = 6'h28;
    localparam logic [5:0] OFS_TRIG   = 6'h2C;

    // ctrl bits
    localparam int CTRL_EN    = 0;
    localparam int CTRL_GO    = 1;
    localparam int CTRL_SIRQ  = 2;
    localparam int CTRL_AIRQ  = 3;
    localparam int CTRL_PEND  = 4;
    // cfg fields
    localparam int CFG_SSTEP  = 0;
    localparam int CFG_DSTEP  = 2;
    localparam int CFG_SMR    = 4;
    // trig fields
    localparam int TRIG_START = 0;
    localparam int TRIG_ABORT = 8;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage
`default_nettype wire

/* dac_ptr_unit.sv */
/*
 one live pointer with its remaining counter: load, step and reload.
 assumes the caller pulses step once per transaction.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_ptr_unit #(
    parameter int AW = dac_pkg::ADDR_W,
    parameter int CW = dac_pkg::CNT_W
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          load,
    input  wire logic          step,
    input  wire logic [1:0]    mode,
    input  wire logic [AW-1:0] start_addr,
    input  wire logic [CW-1:0] size,
    output logic      [AW-1:0] ptr,
    output logic      [CW-1:0] cnt,
    output logic               wrap
);
    wire logic          last;
    wire logic [AW-1:0] ptr_step;
    logic      [AW-1:0] ptr_next;
    logic      [CW-1:0] cnt_next;

    assign last = (cnt == CW'(1)) || (cnt == '0);
    assign wrap = step && last;
    assign ptr_step = (mode == dac_pkg::STEP_INC) ? ptr + AW'(1) :
                      (mode == dac_pkg::STEP_DEC) ? ptr - AW'(1) : ptr;

    always_comb begin
        ptr_next = ptr;
        cnt_next = cnt;
        if (load || wrap) begin
            ptr_next = start_addr;
            cnt_next = size;
        end else if (step) begin
            ptr_next = ptr_step;
            cnt_next = cnt - CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= '0;
            cnt <= '0;
        end else begin
            ptr <= ptr_next;
            cnt <= cnt_next;
        end
    end
endmodule
`default_nettype wire

/* dac_trig_sync.sv */
/*
 two-flop synchroniser and rising-edge detect for a selected trigger line.
 assumes the trigger lines are asynchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_trig_sync #(
    parameter int N  = dac_pkg::NUM_TRIG,
    parameter int SW = dac_pkg::TSEL_W
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic [N-1:0]  lines,
    input  wire logic [SW-1:0] sel,
    output logic               rise
);
    logic [N-1:0] s1_reg;
    logic [N-1:0] s2_reg;
    logic         last_reg;
    wire  logic   cur;

    assign cur  = s2_reg[sel];
    assign rise = cur && !last_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            last_reg <= 1'b0;
        end else begin
            s1_reg   <= lines;
            s2_reg   <= s1_reg;
            last_reg <= cur;
        end
    end
endmodule
`default_nettype wire

/* dac_channel.sv */
/*
 one byte-wide dma channel: avalon-mm register slave, read/write transaction
 engine on the shared buses, live pointers and counters, start and abort triggers.
 assumes an external arbiter that grants the bus one cycle at a time and that
 the memory returns read data in the granted read cycle.
*/
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module dac_channel #(
    parameter int AW = dac_pkg::ADDR_W,
    parameter int CW = dac_pkg::CNT_W,
    parameter int NT = dac_pkg::NUM_TRIG,
    parameter int SW = dac_pkg::TSEL_W
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // avalon-mm slave
    input  wire logic [5:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    // arbiter
    output logic               bus_request,
    input  wire logic          bus_grant,
    // shared memory buses
    output logic               mem_read,
    output logic      [1:0]    mem_region,
    output logic      [AW-1:0] mem_read_addr,
    input  wire logic [7:0]    mem_read_data,
    output logic               mem_write,
    output logic      [AW-1:0] mem_write_addr,
    output logic      [7:0]    mem_write_data,
    output logic               mirror_access,
    // triggers
    input  wire logic [NT-1:0] start_trig_lines,
    input  wire logic [NT-1:0] abort_trig_lines,
    // status
    output logic               write_pending_flag,
    output logic               message_go
);
    //////////////////////////////////////////////////////////////////////////
    // registers
    logic          enable_reg;
    logic          go_reg;
    logic          start_trigger_sample_en;
    logic          abort_trigger_sample_en;
    logic          pend_reg;
    logic [1:0]    src_address_step;
    logic [1:0]    dst_address_step;
    logic [1:0]    src_memory_region;
    logic [AW-1:0] src_start_address;
    logic [AW-1:0] dst_start_address;
    logic [CW-1:0] src_message_size;
    logic [CW-1:0] dst_message_size;
    logic [7:0]    holding_buffer;
    logic [SW-1:0] start_trigger_select;
    logic [SW-1:0] abort_trigger_select;
    logic          load_reg;
    logic          ack_reg;
    logic [31:0]   rdata_reg;
    logic          mem_read_reg;
    logic          mem_write_reg;
    logic          req_reg;
    logic          wait_reg;

    wire logic [AW-1:0] src_live_pointer;
    wire logic [AW-1:0] dst_live_pointer;
    wire logic [CW-1:0] src_remaining_count;
    wire logic [CW-1:0] dst_remaining_count;
    wire logic          src_wrap;
    wire logic          dst_wrap;
    wire logic          start_rise;
    wire logic          abort_rise;

    //////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic access;
    wire logic wr;
    wire logic rd_phase;
    wire logic wr_phase;
    wire logic step;
    wire logic abort_now;
    wire logic hw_start;
    wire logic sw_go_set;
    wire logic sw_go_clr;
    wire logic msg_end;
    wire logic ctrl_wr;
    wire logic [31:0] rd_mux;
    wire logic dst_in_ram;

    assign access    = (avs_read || avs_write) && !ack_reg;
    assign wr        = avs_write && !ack_reg && avs_byteenable[0];
    assign ctrl_wr   = wr && (avs_address == dac_pkg::OFS_CTRL);
    assign sw_go_set = ctrl_wr && avs_writedata[dac_pkg::CTRL_GO]
                       && enable_reg && !go_reg;
    assign sw_go_clr = ctrl_wr && !avs_writedata[dac_pkg::CTRL_GO];
    assign abort_now = abort_rise && abort_trigger_sample_en;
    assign hw_start  = start_rise && start_trigger_sample_en && enable_reg;
    assign dst_in_ram = 1'b1;
    // grant-gated phases: read when buffer empty, write when full
    assign rd_phase  = go_reg && bus_grant && !pend_reg;
    assign wr_phase  = bus_grant && pend_reg && go_reg && dst_in_ram;
    assign step      = wr_phase;
    assign msg_end   = src_wrap || dst_wrap;

    assign rd_mux =
        (avs_address == dac_pkg::OFS_CTRL) ? 32'({pend_reg, abort_trigger_sample_en,
                                              start_trigger_sample_en, go_reg, enable_reg}) :
        (avs_address == dac_pkg::OFS_CFG)  ? 32'({src_memory_region, dst_address_step,
                                              src_address_step}) :
        (avs_address == dac_pkg::OFS_SSA)  ? 32'(src_start_address) :
        (avs_address == dac_pkg::OFS_DSA)  ? 32'(dst_start_address) :
        (avs_address == dac_pkg::OFS_SSZ)  ? 32'(src_message_size) :
        (avs_address == dac_pkg::OFS_DSZ)  ? 32'(dst_message_size) :
        (avs_address == dac_pkg::OFS_SPTR) ? 32'(src_live_pointer) :
        (avs_address == dac_pkg::OFS_DPTR) ? 32'(dst_live_pointer) :
        (avs_address == dac_pkg::OFS_SCNT) ? 32'(src_remaining_count) :
        (avs_address == dac_pkg::OFS_DCNT) ? 32'(dst_remaining_count) :
        (avs_address == dac_pkg::OFS_BUF)  ? 32'(holding_buffer) :
        (avs_address == dac_pkg::OFS_TRIG) ? (32'(start_trigger_select)
                                              | (32'(abort_trigger_select) << dac_pkg::TRIG_ABORT)) :
        dac_pkg::RD_UNMAPPED;

    //////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer on the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= access;
            wait_reg  <= !access;
            rdata_reg <= rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control and configuration
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg              <= 1'b0;
            start_trigger_sample_en <= 1'b0;
            abort_trigger_sample_en <= 1'b0;
            src_address_step        <= dac_pkg::STEP_FIXED;
            dst_address_step        <= dac_pkg::STEP_FIXED;
            src_memory_region       <= dac_pkg::REG_RAM;
            src_start_address       <= '0;
            dst_start_address       <= '0;
            src_message_size        <= '0;
            dst_message_size        <= '0;
            start_trigger_select    <= '0;
            abort_trigger_select    <= '0;
        end else begin
            if (ctrl_wr) begin
                enable_reg              <= avs_writedata[dac_pkg::CTRL_EN];
                start_trigger_sample_en <= avs_writedata[dac_pkg::CTRL_SIRQ];
                abort_trigger_sample_en <= avs_writedata[dac_pkg::CTRL_AIRQ];
            end
            if (abort_now) begin
                start_trigger_sample_en <= 1'b0;
                abort_trigger_sample_en <= 1'b0;
            end
            if (wr && avs_address == dac_pkg::OFS_CFG) begin
                src_address_step  <= avs_writedata[dac_pkg::CFG_SSTEP +: 2];
                dst_address_step  <= avs_writedata[dac_pkg::CFG_DSTEP +: 2];
                src_memory_region <= avs_writedata[dac_pkg::CFG_SMR +: 2];
            end
            if (wr && avs_address == dac_pkg::OFS_SSA)
                src_start_address <= avs_writedata[AW-1:0];
            if (wr && avs_address == dac_pkg::OFS_DSA)
                dst_start_address <= avs_writedata[AW-1:0];
            if (wr && avs_address == dac_pkg::OFS_SSZ)
                src_message_size <= avs_writedata[CW-1:0];
            if (wr && avs_address == dac_pkg::OFS_DSZ)
                dst_message_size <= avs_writedata[CW-1:0];
            if (wr && avs_address == dac_pkg::OFS_TRIG) begin
                start_trigger_select <= avs_writedata[dac_pkg::TRIG_START +: SW];
                abort_trigger_select <= avs_writedata[dac_pkg::TRIG_ABORT +: SW];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // message go, buffer and pending flag
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            go_reg         <= 1'b0;
            pend_reg       <= 1'b0;
            holding_buffer <= 8'h00;
            load_reg       <= 1'b0;
        end else begin
            load_reg <= ctrl_wr && avs_writedata[dac_pkg::CTRL_EN] && !enable_reg;
            if (abort_now || (ctrl_wr && !avs_writedata[dac_pkg::CTRL_EN]))
                go_reg <= 1'b0;
            else if (sw_go_set || hw_start)
                go_reg <= 1'b1;
            else if (msg_end || sw_go_clr)
                go_reg <= 1'b0;
            if (rd_phase) begin
                holding_buffer <= mem_read_data;
                pend_reg       <= 1'b1;
            end else if (wr_phase) begin
                pend_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pointer, counter and trigger units
    dac_ptr_unit #(.AW(AW), .CW(CW)) u_src (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (load_reg),
        .step       (step),
        .mode       (src_address_step),
        .start_addr (src_start_address),
        .size       (src_message_size),
        .ptr        (src_live_pointer),
        .cnt        (src_remaining_count),
        .wrap       (src_wrap)
    );

    dac_ptr_unit #(.AW(AW), .CW(CW)) u_dst (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (load_reg),
        .step       (step),
        .mode       (dst_address_step),
        .start_addr (dst_start_address),
        .size       (dst_message_size),
        .ptr        (dst_live_pointer),
        .cnt        (dst_remaining_count),
        .wrap       (dst_wrap)
    );

    dac_trig_sync #(.N(NT), .SW(SW)) u_start (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .lines   (start_trig_lines),
        .sel     (start_trigger_select),
        .rise    (start_rise)
    );

    dac_trig_sync #(.N(NT), .SW(SW)) u_abort (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .lines   (abort_trig_lines),
        .sel     (abort_trigger_select),
        .rise    (abort_rise)
    );

    //////////////////////////////////////////////////////////////////////////
    // registered bus strobes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_read_reg  <= 1'b0;
            mem_write_reg <= 1'b0;
            req_reg       <= 1'b0;
        end else begin
            mem_read_reg  <= rd_phase;
            mem_write_reg <= wr_phase;
            req_reg       <= go_reg && !abort_now;
        end
    end

    // read strobe and address are combinational with grant so data returns same cycle
    assign mem_read        = rd_phase;
    assign mem_region      = src_memory_region;
    assign mem_read_addr   = src_live_pointer;
    assign mem_write       = wr_phase;
    assign mem_write_addr  = dst_live_pointer;
    assign mem_write_data  = holding_buffer;
    assign mirror_access   = rd_phase || wr_phase;
    assign bus_request     = req_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign write_pending_flag = pend_reg;
    assign message_go      = go_reg;

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_write_needs_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(write_pending_flag) |-> mem_read_reg) else $error("buffer filled without read");
    a_buffer_written: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_phase |=> mem_write_data == $past(mem_read_data))
        else $error("buffer mismatch");
    a_pend_only_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(write_pending_flag) |-> mem_write_reg) else $error("pending cleared without write");
    a_counts_together: assert property (@(posedge sys_clk) disable iff (!rst_n)
        step && !src_wrap && !dst_wrap && !load_reg
        |=> src_remaining_count == $past(src_remaining_count) - CW'(1)
            && dst_remaining_count == $past(dst_remaining_count) - CW'(1))
        else $error("counters not stepped together");
    a_step_dec: assert property (@(posedge sys_clk) disable iff (!rst_n)
        step && !dst_wrap && !load_reg && dst_address_step == dac_pkg::STEP_DEC
        |=> dst_live_pointer == $past(dst_live_pointer) - AW'(1))
        else $error("decrement wrong");
    a_pend_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_phase |=> write_pending_flag) else $error("pending not set");
    a_pend_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_phase |=> !write_pending_flag) else $error("pending not cleared");
    a_grant_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mem_read || mem_write) |-> bus_grant) else $error("bus without grant");
    a_abort_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        abort_now |=> !message_go && !start_trigger_sample_en && !abort_trigger_sample_en)
        else $error("abort left bits set");
    a_start_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(go_reg) |-> $past(enable_reg)) else $error("start while disabled");
    a_one_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(mem_read && mem_write)) else $error("read and write together");
    a_step_inc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        step && !src_wrap && !load_reg && src_address_step == dac_pkg::STEP_INC
        |=> src_live_pointer == $past(src_live_pointer) + AW'(1))
        else $error("increment wrong");
endmodule
`default_nettype wire

/* dac_mem_model.sv */
/*
 partner: system arbiter and byte-wide shared memory for the dma channel.
 assumes the channel strobes mem_read or mem_write only in granted cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_mem_model (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic [1:0]               gmode,
    input  wire logic                     bus_request,
    output logic                          bus_grant,
    input  wire logic                     mem_read,
    input  wire logic [1:0]               mem_region,
    input  wire logic [dac_pkg::ADDR_W-1:0] mem_read_addr,
    output logic      [7:0]               mem_read_data,
    input  wire logic                     mem_write,
    input  wire logic [dac_pkg::ADDR_W-1:0] mem_write_addr,
    input  wire logic [7:0]               mem_write_data
);
    logic                       tog_reg;
    logic [7:0]                 last_reg;
    int                         wr_cnt;
    logic [dac_pkg::ADDR_W-1:0] wr_addr [64];
    logic [7:0]                 wr_data [64];
    //////////////////////////////////////////////////////////////////////////
    // gmode 1 stalls the cpu, gmode 2 hands out every other idle slot
    assign bus_grant = bus_request
                       & ((gmode == 2'h1) | ((gmode == 2'h2) & tog_reg));
    // content depends on region; released bus shows the inverse of the last byte
    assign mem_read_data = mem_read ? (mem_read_addr[7:0] ^ {mem_region, 6'h00}) : ~last_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_reg  <= 1'b0;
            last_reg <= 8'h00;
            wr_cnt   <= 0;
        end else begin
            tog_reg <= ~tog_reg;
            if (mem_read) begin
                last_reg <= mem_read_data;
            end
            if (mem_write) begin
                wr_addr[wr_cnt] <= mem_write_addr;
                wr_data[wr_cnt] <= mem_write_data;
                wr_cnt          <= wr_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* dac_channel_test.sv */
/*
 self-checking bench for dac_channel: avalon register access, transfers, triggers.
 assumes dac_mem_model as arbiter and memory on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_channel_test;
    logic                       sys_clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic [5:0]                 avs_address = 6'h00;
    logic                       avs_read = 1'b0;
    logic                       avs_write = 1'b0;
    logic [31:0]                avs_writedata = 32'h0000_0000;
    logic [31:0]                avs_readdata;
    logic                       avs_waitrequest;
    logic                       bus_request, bus_grant, mem_read, mem_write;
    logic [1:0]                 mem_region;
    logic [1:0]                 gmode = 2'h0;
    logic [dac_pkg::ADDR_W-1:0] mem_read_addr, mem_write_addr;
    logic [7:0]                 mem_read_data, mem_write_data;
    logic [7:0]                 st_lines = 8'h00;
    logic [7:0]                 ab_lines = 8'h00;
    logic                       write_pending_flag, message_go, mirror_access;
    int                         n_mismatch = 0;
    int                         comparisons = 0;
    int                         cycles = 0;
    int                         base;
    logic [31:0]                q;
    logic [21:0]                ssa = 22'h00_0180;
    logic [21:0]                dsa = 22'h00_0240;
    always #5 sys_clk = ~sys_clk;
    dac_channel u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .bus_request(bus_request), .bus_grant(bus_grant), .mem_read(mem_read),
        .mem_region(mem_region), .mem_read_addr(mem_read_addr), .mem_read_data(mem_read_data),
        .mem_write(mem_write), .mem_write_addr(mem_write_addr),
        .mem_write_data(mem_write_data), .mirror_access(mirror_access),
        .start_trig_lines(st_lines),
        .abort_trig_lines(ab_lines), .write_pending_flag(write_pending_flag),
        .message_go(message_go));
    dac_mem_model u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .gmode(gmode),
        .bus_request(bus_request), .bus_grant(bus_grant), .mem_read(mem_read),
        .mem_region(mem_region), .mem_read_addr(mem_read_addr), .mem_read_data(mem_read_data),
        .mem_write(mem_write), .mem_write_addr(mem_write_addr), .mem_write_data(mem_write_data));
    //////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_go(input logic v);
        for (int n = 0; n < 300 && message_go !== v; n++) @(negedge sys_clk);
    endtask
    function automatic logic [21:0] stp(logic [21:0] a, logic [1:0] m, int k);
        return (m == dac_pkg::STEP_INC) ? a + 22'(k) : (m == dac_pkg::STEP_DEC) ? a - 22'(k) : a;
    endfunction
    //////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        av(0, dac_pkg::OFS_CTRL, 0);
        chk(q, 32'h0000_0000);
        av(0, 6'h30, 0);
        chk(q, dac_pkg::RD_UNMAPPED);
        $display("test reset done");
    endtask
    task automatic t_runs;
        logic [1:0] ss [3] = '{dac_pkg::STEP_INC, dac_pkg::STEP_FIXED, dac_pkg::STEP_DEC};
        logic [1:0] ds [3] = '{dac_pkg::STEP_DEC, dac_pkg::STEP_INC, dac_pkg::STEP_FIXED};
        logic [1:0] rg [3] = '{dac_pkg::REG_FLASH, dac_pkg::REG_EEP, dac_pkg::REG_RAM};
        int sz [3] = '{3, 2, 4};
        int dz [3] = '{3, 5, 4};
        for (int i = 0; i < 3; i++) begin
            gmode <= 2'(1 + i % 2);
            av(1, dac_pkg::OFS_CTRL, 0);
            av(1, dac_pkg::OFS_CFG, 32'({rg[i], ds[i], ss[i]}));
            av(1, dac_pkg::OFS_SSA, 32'(ssa));
            av(1, dac_pkg::OFS_DSA, 32'(dsa));
            av(1, dac_pkg::OFS_SSZ, 32'(sz[i]));
            av(1, dac_pkg::OFS_DSZ, 32'(dz[i]));
            av(1, dac_pkg::OFS_CTRL, 32'h0000_0001);
            base = u_mem.wr_cnt;
            av(1, dac_pkg::OFS_CTRL, 32'h0000_0003);
            wait_go(1'b0);
            chk(32'(u_mem.wr_cnt - base), 32'(sz[i]));
            for (int k = 0; k < sz[i]; k++) begin
                chk(32'(u_mem.wr_addr[base+k]),
                    32'(stp(dsa, ds[i], k)));
                chk(32'(u_mem.wr_data[base+k]),
                    32'(8'(stp(ssa, ss[i], k)) ^ {rg[i], 6'h00}));
            end
            av(0, dac_pkg::OFS_SPTR, 0);
            chk(q, 32'(ssa));
        end
        $display("test runs done");
    endtask
    task automatic t_abort;
        gmode <= 2'h0;
        av(1, dac_pkg::OFS_TRIG, 32'h0000_0205);
        av(1, dac_pkg::OFS_CTRL, 32'h0000_000B);
        base = u_mem.wr_cnt;
        chk(message_go, 1'b1);
        ab_lines <= 8'h04;
        repeat (4) @(posedge sys_clk);
        ab_lines <= 8'h00;
        repeat (6) @(posedge sys_clk);
        av(0, dac_pkg::OFS_CTRL, 0);
        chk(q, 32'h0000_0001);
        chk(32'(u_mem.wr_cnt - base), 0);
        av(0, dac_pkg::OFS_SPTR, 0);
        chk(q, 32'(ssa));
        $display("test abort done");
    endtask
    task automatic t_start;
        av(1, dac_pkg::OFS_CTRL, 0);
        av(1, dac_pkg::OFS_CTRL, 32'h0000_0002);
        repeat (3) @(negedge sys_clk);
        chk(message_go, 1'b0);
        av(1, dac_pkg::OFS_CTRL, 32'h0000_0001);
        av(1, dac_pkg::OFS_CTRL, 32'h0000_0005);
        gmode <= 2'h2;
        base = u_mem.wr_cnt;
        st_lines <= 8'h20;
        wait_go(1'b1);
        chk(message_go, 1'b1);
        for (int n = 0; n < 20 && mem_read !== 1'b1; n++) @(negedge sys_clk);
        chk(mirror_access, 1'b1);
        @(negedge sys_clk);
        chk(write_pending_flag, 1'b1);
        wait_go(1'b0);
        @(posedge sys_clk);
        st_lines <= 8'h00;
        chk(write_pending_flag, 1'b0);
        chk(32'(u_mem.wr_cnt - base), 4);
        $display("test start done");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_runs();
        t_abort();
        t_start();
        end_of_test();
    end
endmodule
`default_nettype wire
